// *** logic/scf_defines.vh ***
// Purpose: constants for the serial CPU fetch and decode block
// Assumes: doc bit k of a word sits in vector bit 23-k
// Notes: doc bit 0 (sign) is vector bit 23, serial LSB is bit 0
`ifndef SCF_DEFINES_VH
`define SCF_DEFINES_VH

`define SCF_W 24
`define SCF_AW 14
`define SCF_LAST_BIT 5'h17
`define SCF_PC_RST 14'h0000
`define SCF_NSYNC 37

// Instruction fields
`define SCF_IDX_BIT 22
`define SCF_PO_BIT 21
`define SCF_OP_HI 20
`define SCF_OP_LO 15
`define SCF_IND_BIT 14
`define SCF_ADDR_HI 13
`define SCF_SIGN_BIT 23
`define SCF_XNINE_BIT 14

// Opcodes, octal codes given here in hex
`define SCF_OP_HLT 6'h00
`define SCF_OP_BRU 6'h01
`define SCF_OP_EOM 6'h02
`define SCF_OP_MIY 6'h08
`define SCF_OP_MIW 6'h0a
`define SCF_OP_POT 6'h0b
`define SCF_OP_ETR 6'h0c
`define SCF_OP_MRG 6'h0e
`define SCF_OP_EOR 6'h0f
`define SCF_OP_NOP 6'h10
`define SCF_OP_EXU 6'h13
`define SCF_OP_WIM 6'h1a
`define SCF_OP_STA 6'h1d
`define SCF_OP_STB 6'h1e
`define SCF_OP_STX 6'h1f
`define SCF_OP_SKS 6'h20
`define SCF_OP_BRX 6'h21
`define SCF_OP_BRM 6'h23
`define SCF_OP_REG 6'h26
`define SCF_OP_BRR 6'h29
`define SCF_OP_SKN 6'h2b
`define SCF_OP_SUB 6'h2c
`define SCF_OP_ADD 6'h2d
`define SCF_OP_MIN 6'h31
`define SCF_OP_RSG 6'h36
`define SCF_OP_LSG 6'h37
`define SCF_OP_LDX 6'h39
`define SCF_OP_LDB 6'h3d
`define SCF_OP_LDA 6'h3e
`define SCF_OP_EAX 6'h3f

// Subcodes in address bits 13:12 for 46, 66, 67
`define SCF_SUB_XAB 2'h0
`define SCF_SUB_BAC 2'h1
`define SCF_SUB_ABC 2'h2
`define SCF_SUB_CLR 2'h3
`define SCF_SUB_CYC 2'h2
`define SCF_SUB_NOD 2'h1

`endif

// *** logic/scf_shift_reg.v ***
// Purpose: 24-bit operand shift register with parallel load
// Assumes: shifts toward bit 0, least significant bit leaves first
// Notes: load wins over shift
`timescale 1ns/1ps
`include "scf_defines.vh"

module scf_shift_reg (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Control
    input wire load_in,
    input wire shift_in,
    input wire [`SCF_W-1:0] load_data_in,
    input wire serial_in,
    // Results
    output wire serial_out,
    output wire [`SCF_W-1:0] data_out
);
    reg [`SCF_W-1:0] data;

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            data <= 24'h000000;
        end else if (load_in) begin
            data <= load_data_in;
        end else if (shift_in) begin
            data <= {serial_in, data[`SCF_W-1:1]};
        end
    end

    assign serial_out = data[0];
    assign data_out = data;
endmodule

// *** logic/scf_fetch_decode.v ***
// Purpose: instruction fetch, decode and execution sequencing
// Assumes: core memory on clk_in, read data valid in the same cycle that rd is high
// Notes: one clock per serial bit; 24 clocks make a serial word time
`timescale 1ns/1ps
`include "scf_defines.vh"

module scf_fetch_decode (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Core memory
    input wire [23:0] mem_rdata_in,
    output reg [13:0] mem_addr_out,
    output reg [23:0] mem_wdata_out,
    output reg mem_rd_out,
    output reg mem_wr_out,
    // Channel and signal pins
    input wire [7:0] signal_in,
    input wire y_ready_in,
    input wire w_ready_in,
    input wire p_ready_in,
    input wire w_full_in,
    input wire [23:0] w_word_in,
    // Machine state
    output reg [13:0] pc_out,
    output reg [5:0] opcode_out,
    output reg [23:0] acc_out,
    output reg [23:0] ext_out,
    output reg [23:0] index_out,
    output reg [23:0] word_assembly_register_out,
    output reg [23:0] y_out,
    output reg [23:0] par_out,
    output reg war_load_out,
    output reg halted_out,
    output reg instr_done_out,
    output reg [3:0] word_times_out
);
    localparam ST_FETCH = 10'h001;
    localparam ST_DECODE = 10'h002;
    localparam ST_INDIR = 10'h004;
    localparam ST_ROUTE = 10'h008;
    localparam ST_OPER = 10'h010;
    localparam ST_WAIT = 10'h020;
    localparam ST_SERIAL = 10'h040;
    localparam ST_SHIFT = 10'h080;
    localparam ST_WRITE = 10'h100;
    localparam ST_HALT = 10'h200;

    reg [9:0] state;
    reg rd_ph;
    reg [13:0] ea;
    reg [4:0] bit_cnt;
    reg [5:0] sh_cnt;
    reg carry;
    reg [3:0] wt_cnt;
    reg started;
    reg [`SCF_NSYNC-1:0] sync1;
    reg [`SCF_NSYNC-1:0] sync2;

    wire [7:0] sig_s = sync2[7:0];
    wire y_rdy = sync2[8];
    wire w_rdy = sync2[9];
    wire p_rdy = sync2[10];
    wire w_full = sync2[11];
    wire [23:0] w_word = sync2[35:12];

    wire c_sout;
    wire [23:0] c_data;
    wire [5:0] op = opcode_out;
    wire is_store = (op == `SCF_OP_STA) | (op == `SCF_OP_STB) |
        (op == `SCF_OP_STX);
    wire c_load = rd_ph & ((state == ST_FETCH) | (state == ST_OPER));
    wire c_shift = (state == ST_SERIAL);
    // Store source circulates so it is intact after 24 shifts
    wire c_sin = (op == `SCF_OP_STA) ? acc_out[0] :
        (op == `SCF_OP_STB) ? ext_out[0] : index_out[0];
    wire [13:0] idx_addr = c_data[`SCF_ADDR_HI:0] +
        (c_data[`SCF_IDX_BIT] ? index_out[13:0] : 14'h0000);
    wire mbit = (op == `SCF_OP_SUB) ? ~c_sout : c_sout;
    wire sum_bit = acc_out[0] ^ mbit ^ carry;
    wire sum_cy = (acc_out[0] & mbit) | (carry & (acc_out[0] ^ mbit));
    wire [23:0] x_inc = index_out + 24'h000001;
    wire [47:0] ab = {acc_out, ext_out};

    // Operations that read a memory operand before executing
    function needs_operand;
        input [5:0] code;
        begin
            case (code)
                `SCF_OP_ETR, `SCF_OP_MRG, `SCF_OP_EOR, `SCF_OP_SUB,
                `SCF_OP_ADD, `SCF_OP_LDA, `SCF_OP_LDB, `SCF_OP_LDX,
                `SCF_OP_BRR, `SCF_OP_SKN, `SCF_OP_MIN, `SCF_OP_MIY,
                `SCF_OP_MIW, `SCF_OP_POT, `SCF_OP_EXU:
                    needs_operand = 1'b1;
                default:
                    needs_operand = 1'b0;
            endcase
        end
    endfunction

    // Ready condition of the channel each I/O code waits on
    function chan_ready;
        input [5:0] code;
        input yr;
        input wr;
        input pr;
        input wf;
        begin
            case (code)
                `SCF_OP_MIY: chan_ready = yr;
                `SCF_OP_MIW: chan_ready = wr;
                `SCF_OP_POT: chan_ready = pr;
                `SCF_OP_WIM: chan_ready = wf;
                default: chan_ready = 1'b1;
            endcase
        end
    endfunction

    scf_shift_reg u_creg (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .load_in(c_load),
        .shift_in(c_shift),
        .load_data_in(mem_rdata_in),
        .serial_in(c_sin),
        .serial_out(c_sout),
        .data_out(c_data)
    );

    // Pins cross in through two flops; w_word is stable while full
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync1 <= 37'h0000000000;
            sync2 <= 37'h0000000000;
        end else begin
            sync1 <= {1'b0, w_word_in, w_full_in, p_ready_in,
                w_ready_in, y_ready_in, signal_in};
            sync2 <= sync1;
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= ST_FETCH;
            rd_ph <= 1'b0;
            ea <= 14'h0000;
            bit_cnt <= 5'h00;
            sh_cnt <= 6'h00;
            carry <= 1'b0;
            wt_cnt <= 4'h0;
            started <= 1'b0;
            mem_addr_out <= 14'h0000;
            mem_wdata_out <= 24'h000000;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            pc_out <= `SCF_PC_RST;
            opcode_out <= `SCF_OP_NOP;
            acc_out <= 24'h000000;
            ext_out <= 24'h000000;
            index_out <= 24'h000000;
            word_assembly_register_out <= 24'h000000;
            y_out <= 24'h000000;
            par_out <= 24'h000000;
            war_load_out <= 1'b0;
            halted_out <= 1'b0;
            instr_done_out <= 1'b0;
            word_times_out <= 4'h0;
        end else begin
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            war_load_out <= 1'b0;
            instr_done_out <= 1'b0;
            case (state)
                ST_FETCH: begin
                    if (!rd_ph) begin
                        mem_addr_out <= pc_out;
                        pc_out <= pc_out + 14'h0001;
                        mem_rd_out <= 1'b1;
                        rd_ph <= 1'b1;
                        word_times_out <= wt_cnt;
                        instr_done_out <= started;
                        started <= 1'b1;
                        wt_cnt <= 4'h1;
                    end else begin
                        mem_wdata_out <= mem_rdata_in;
                        rd_ph <= 1'b0;
                        state <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    // Bit 0 (relative) plays no part here
                    opcode_out <= c_data[`SCF_OP_HI:`SCF_OP_LO];
                    if (c_data[`SCF_PO_BIT]) begin
                        // Entry address is the 7 bits 2..8
                        pc_out <= {7'h00, c_data[`SCF_PO_BIT:`SCF_OP_LO]};
                        state <= ST_FETCH;
                    end else if (c_data[`SCF_IND_BIT]) begin
                        mem_addr_out <= idx_addr;
                        state <= ST_INDIR;
                    end else begin
                        ea <= idx_addr;
                        state <= ST_ROUTE;
                    end
                end
                ST_INDIR: begin
                    if (!rd_ph) begin
                        mem_rd_out <= 1'b1;
                        rd_ph <= 1'b1;
                    end else begin
                        rd_ph <= 1'b0;
                        wt_cnt <= wt_cnt + 4'h1;
                        ea <= mem_rdata_in[`SCF_ADDR_HI:0];
                        mem_addr_out <= mem_rdata_in[`SCF_ADDR_HI:0];
                        // Chained indirection keeps reading
                        if (!mem_rdata_in[`SCF_IND_BIT])
                            state <= ST_ROUTE;
                    end
                end
                ST_ROUTE: begin
                    mem_addr_out <= ea;
                    bit_cnt <= 5'h00;
                    carry <= (op == `SCF_OP_SUB);
                    state <= ST_FETCH;
                    if (needs_operand(op)) begin
                        state <= ST_OPER;
                    end else if (is_store) begin
                        state <= ST_SERIAL;
                    end else begin
                        case (op)
                            `SCF_OP_HLT: begin
                                halted_out <= 1'b1;
                                state <= ST_HALT;
                            end
                            `SCF_OP_BRU: pc_out <= ea;
                            `SCF_OP_WIM: state <= ST_WAIT;
                            `SCF_OP_SKS: begin
                                if (!sig_s[ea[2:0]])
                                    pc_out <= pc_out + 14'h0001;
                            end
                            `SCF_OP_BRX: begin
                                index_out <= x_inc;
                                if (x_inc[`SCF_XNINE_BIT])
                                    pc_out <= ea;
                            end
                            `SCF_OP_BRM: begin
                                mem_wdata_out <= {10'h000, pc_out};
                                pc_out <= ea + 14'h0001;
                                state <= ST_WRITE;
                            end
                            `SCF_OP_EAX: index_out <= {10'h000, ea};
                            `SCF_OP_REG: begin
                                case (ea[13:12])
                                    `SCF_SUB_XAB: begin
                                        acc_out <= ext_out;
                                        ext_out <= acc_out;
                                    end
                                    `SCF_SUB_BAC: begin
                                        acc_out <= ext_out;
                                        ext_out <= 24'h000000;
                                    end
                                    `SCF_SUB_ABC: begin
                                        ext_out <= acc_out;
                                        acc_out <= 24'h000000;
                                    end
                                    default: begin
                                        acc_out <= 24'h000000;
                                        ext_out <= 24'h000000;
                                    end
                                endcase
                            end
                            `SCF_OP_RSG, `SCF_OP_LSG: begin
                                sh_cnt <= ea[5:0];
                                state <= ST_SHIFT;
                            end
                            default: state <= ST_FETCH;
                        endcase
                    end
                end
                ST_OPER: begin
                    if (!rd_ph) begin
                        mem_rd_out <= 1'b1;
                        rd_ph <= 1'b1;
                    end else begin
                        rd_ph <= 1'b0;
                        mem_wdata_out <= mem_rdata_in;
                        state <= ST_SERIAL;
                        case (op)
                            `SCF_OP_EXU: state <= ST_DECODE;
                            `SCF_OP_BRR: begin
                                pc_out <= mem_rdata_in[13:0] + 14'h0001;
                                wt_cnt <= wt_cnt + 4'h1;
                                state <= ST_FETCH;
                            end
                            `SCF_OP_SKN: begin
                                if (mem_rdata_in[`SCF_SIGN_BIT])
                                    pc_out <= pc_out + 14'h0001;
                                wt_cnt <= wt_cnt + 4'h1;
                                state <= ST_FETCH;
                            end
                            `SCF_OP_MIN: begin
                                mem_wdata_out <= mem_rdata_in + 24'h000001;
                                wt_cnt <= wt_cnt + 4'h1;
                                state <= ST_WRITE;
                            end
                            `SCF_OP_MIY, `SCF_OP_MIW, `SCF_OP_POT:
                                state <= ST_WAIT;
                            default: state <= ST_SERIAL;
                        endcase
                    end
                end
                ST_WAIT: begin
                    // Idles here until the channel is ready
                    if (chan_ready(op, y_rdy, w_rdy, p_rdy, w_full)) begin
                        if (op == `SCF_OP_WIM) begin
                            mem_wdata_out <= w_word;
                            state <= ST_WRITE;
                        end else begin
                            state <= ST_SERIAL;
                        end
                    end
                end
                ST_SERIAL: begin
                    // One operand bit per clock, LSB first
                    case (op)
                        `SCF_OP_ADD, `SCF_OP_SUB: begin
                            acc_out <= {sum_bit, acc_out[23:1]};
                            carry <= sum_cy;
                        end
                        `SCF_OP_MRG:
                            acc_out <= {acc_out[0] | c_sout, acc_out[23:1]};
                        `SCF_OP_EOR:
                            acc_out <= {acc_out[0] ^ c_sout, acc_out[23:1]};
                        `SCF_OP_ETR:
                            acc_out <= {acc_out[0] & c_sout, acc_out[23:1]};
                        `SCF_OP_LDA: acc_out <= {c_sout, acc_out[23:1]};
                        `SCF_OP_LDB: ext_out <= {c_sout, ext_out[23:1]};
                        `SCF_OP_LDX: index_out <= {c_sout, index_out[23:1]};
                        `SCF_OP_STA: acc_out <= {acc_out[0], acc_out[23:1]};
                        `SCF_OP_STB: ext_out <= {ext_out[0], ext_out[23:1]};
                        `SCF_OP_STX:
                            index_out <= {index_out[0], index_out[23:1]};
                        `SCF_OP_MIY: y_out <= {c_sout, y_out[23:1]};
                        `SCF_OP_MIW:
                            word_assembly_register_out <= {c_sout,
                                word_assembly_register_out[23:1]};
                        `SCF_OP_POT: par_out <= {c_sout, par_out[23:1]};
                        default: carry <= carry;
                    endcase
                    if (bit_cnt == `SCF_LAST_BIT) begin
                        bit_cnt <= 5'h00;
                        wt_cnt <= wt_cnt + 4'h1;
                        war_load_out <= (op == `SCF_OP_MIW);
                        state <= is_store ? ST_WRITE : ST_FETCH;
                    end else begin
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
                ST_SHIFT: begin
                    if (sh_cnt == 6'h00) begin
                        wt_cnt <= wt_cnt + 4'h1;
                        state <= ST_FETCH;
                    end else begin
                        sh_cnt <= sh_cnt - 6'h01;
                        if (op == `SCF_OP_RSG) begin
                            if (ea[13:12] == `SCF_SUB_CYC)
                                {acc_out, ext_out} <= {ab[0], ab[47:1]};
                            else
                                {acc_out, ext_out} <= {ab[47], ab[47:1]};
                        end else if (ea[13:12] == `SCF_SUB_CYC) begin
                            {acc_out, ext_out} <= {ab[46:0], ab[47]};
                        end else if (ea[13:12] == `SCF_SUB_NOD) begin
                            // Stops once the top two bits differ
                            if (acc_out[23] == acc_out[22]) begin
                                {acc_out, ext_out} <= {ab[46:0], 1'b0};
                                index_out <= index_out - 24'h000001;
                            end else begin
                                sh_cnt <= 6'h00;
                            end
                        end else begin
                            {acc_out, ext_out} <= {ab[46:0], 1'b0};
                        end
                    end
                end
                ST_WRITE: begin
                    if (!rd_ph) begin
                        if (is_store)
                            mem_wdata_out <= c_data;
                        rd_ph <= 1'b1;
                    end else begin
                        mem_wr_out <= 1'b1;
                        rd_ph <= 1'b0;
                        wt_cnt <= wt_cnt + 4'h1;
                        state <= ST_FETCH;
                    end
                end
                ST_HALT: halted_out <= 1'b1;
                default: state <= ST_FETCH;
            endcase
        end
    end
endmodule

// *** verification/scf_mem_model.sv ***
// Purpose: core memory stand-in on the far side of the block
// Assumes: read data stands within the cycle of the read strobe
// Notes: data lines toggle when no read answers, so stale data is never held
`timescale 1ns/1ps

module scf_mem_model (
    // Clock
    input wire clk_in,
    // Access
    input wire [13:0] addr_in,
    input wire rd_in,
    input wire wr_in,
    input wire [23:0] wdata_in,
    // Read data
    output wire [23:0] rdata_out
);
    reg [23:0] mem [0:16383];
    reg [23:0] idle_q;

    initial idle_q = 24'h000000;

    // Block samples at the edge ending the strobe, so answer inside it
    assign rdata_out = rd_in ? mem[addr_in] : idle_q;

    always @(posedge clk_in) begin
        idle_q <= ~idle_q;
        if (wr_in)
            mem[addr_in] <= wdata_in;
    end
endmodule

// *** verification/scf_fetch_decode_monitor.sv ***
// Purpose: port-level checks on the fetch and decode block
// Assumes: one clock domain, synchronous active-low reset
// Notes: fetch-qualified opcode check skips program operator words
`timescale 1ns/1ps

module scf_monitor (
    input wire clk_in,
    input wire rst_n_in,
    input wire [23:0] mem_rdata_in,
    input wire [13:0] mem_addr_out,
    input wire [23:0] mem_wdata_out,
    input wire mem_rd_out,
    input wire mem_wr_out,
    input wire [13:0] pc_out,
    input wire [5:0] opcode_out,
    input wire halted_out,
    input wire instr_done_out,
    input wire [3:0] word_times_out
);
    reg [5:0] ir_op;

    // Latch the fetched opcode field in the strobe cycle
    always @(posedge clk_in) begin
        if (mem_rd_out && instr_done_out)
            ir_op <= mem_rdata_in[20:15];
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_fetch;
        mem_rd_out && instr_done_out && !mem_rdata_in[21];
    endsequence

    property p_rd_pulse;
        mem_rd_out |=> !mem_rd_out;
    endproperty
    property p_wr_pulse;
        mem_wr_out |=> !mem_wr_out;
    endproperty
    property p_excl;
        !(mem_rd_out && mem_wr_out);
    endproperty
    property p_wr_hold;
        mem_wr_out |-> $stable(mem_addr_out) && $stable(mem_wdata_out);
    endproperty
    property p_fetch_pc;
        instr_done_out && mem_rd_out |-> pc_out == mem_addr_out + 14'h1;
    endproperty
    property p_done;
        instr_done_out |-> word_times_out != 4'h0 ##1 !instr_done_out;
    endproperty
    property p_halt;
        halted_out |=> halted_out && !mem_rd_out;
    endproperty
    property p_opcode;
        s_fetch |=> ##[0:2] opcode_out == ir_op;
    endproperty

    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read strobe too long");
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe too long");
    a_excl: assert property (p_excl)
        else $error("read and write together");
    a_wr_hold: assert property (p_wr_hold)
        else $error("write address or data moved");
    a_fetch_pc: assert property (p_fetch_pc)
        else $error("counter not fetch address plus one");
    a_done: assert property (p_done)
        else $error("done pulse or word count wrong");
    a_halt: assert property (p_halt)
        else $error("halt left or fetch after halt");
    a_opcode: assert property (p_opcode)
        else $error("opcode register not loaded");
endmodule

bind scf_fetch_decode scf_monitor u_mon (.clk_in, .rst_n_in,
    .mem_rdata_in, .mem_addr_out, .mem_wdata_out, .mem_rd_out,
    .mem_wr_out, .pc_out, .opcode_out, .halted_out, .instr_done_out,
    .word_times_out);

// *** verification/scf_fetch_decode_tb.sv ***
// Purpose: directed program run through the fetch and decode block
// Assumes: memory model answers within the cycle of each read strobe
// Notes: program and data preloaded; results read back from memory and from the register outputs
`timescale 1ns/1ps

module scf_fetch_decode_tb;
    reg clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg w_ready_in = 1'b0;
    wire [23:0] rdata, wdata, acc, ext, idx, word_assembly_register;
    wire [13:0] addr, pc;
    wire [5:0] op;
    wire [3:0] wt;
    wire rd, wr, halted, done, war_ld;
    integer n_errors = 0;
    integer n_checks = 0;
    integer i;
    integer nw = 0;
    integer nld = 0;
    reg [3:0] got [0:14];
    localparam [59:0] wexp = 60'h223332222233222;
    localparam [455:0] prog = {24'h1f0100, 24'h168101, 24'h0e8102,
        24'h164103, 24'h0e8104, 24'h1c8105, 24'h5f00fe, 24'h070106,
        24'h078107, 24'h060108, 24'h0e8109, 24'h18810a, 24'h158104,
        24'h000000, 24'h118200, 24'h000000, 24'h05010c, 24'h130000,
        24'h000000};
    localparam [311:0] dat = {24'h200001, 24'h3fffff, 24'h000000,
        24'h00010b, 24'h000000, 24'h000002, 24'h0f0f0f, 24'hffff00,
        24'h00ffff, 24'h000000, 24'hffffff, 24'h700000, 24'ha5c3e1};

    scf_fetch_decode uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .mem_rdata_in(rdata), .mem_addr_out(addr), .mem_wdata_out(wdata),
        .mem_rd_out(rd), .mem_wr_out(wr), .signal_in(8'h00),
        .y_ready_in(1'b0), .w_ready_in(w_ready_in), .p_ready_in(1'b0),
        .w_full_in(1'b0), .w_word_in(24'h000000), .pc_out(pc),
        .opcode_out(op), .acc_out(acc), .ext_out(ext), .index_out(idx),
        .word_assembly_register_out(word_assembly_register), .y_out(), .par_out(),
        .war_load_out(war_ld), .halted_out(halted),
        .instr_done_out(done), .word_times_out(wt));

    scf_mem_model mem (.clk_in(clk_in), .addr_in(addr), .rd_in(rd),
        .wr_in(wr), .wdata_in(wdata), .rdata_out(rdata));

    initial begin
        forever #50 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (done && nw < 15) begin
            got[nw] <= wt;
            nw <= nw + 1;
        end
        if (war_ld)
            nld <= nld + 1;
    end

    task chk(input [23:0] g, input [23:0] e);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("BAD %0t got %h expected %h", $time, g, e);
            end
        end
    endtask

    task results;
        begin
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // Bounded wait: s=0 for the buffer-out opcode, s=1 for halt
    task wait_for(input integer s);
        integer k;
        begin
            k = 0;
            while ((s ? halted !== 1'b1 : op !== 6'h0a) && k < 3000) begin
                @(posedge clk_in);
                #1;
                k = k + 1;
            end
            if (k >= 3000) begin
                n_errors = n_errors + 1;
                $display("BAD %0t wait ran out", $time);
                results;
            end
        end
    endtask

    initial begin
        for (i = 0; i < 19; i = i + 1)
            mem.mem[i] = prog[455-24*i -: 24];
        for (i = 0; i < 13; i = i + 1)
            mem.mem[14'h100+i] = dat[311-24*i -: 24];
        mem.mem[14'h201] = 24'h148200;
        repeat (10) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        wait_for(0);
        // Channel held not ready: the word buffer must not move
        repeat (40) @(posedge clk_in);
        #1;
        chk(word_assembly_register, 24'h000000);
        w_ready_in = 1'b1;
        wait_for(1);
        chk(word_assembly_register, 24'ha5c3e1);
        chk(nld[23:0], 24'h000001);
        chk(mem.mem[14'h102], 24'h600000);
        chk(mem.mem[14'h104], 24'hf00000);
        chk(mem.mem[14'h109], 24'h00f00f);
        chk(mem.mem[14'h10a], 24'h000000);
        chk(mem.mem[14'h200], 24'h00000f);
        chk(ext, 24'h00f00f);
        chk(acc, 24'h000000);
        chk(idx, 24'h000002);
        chk({10'h000, pc}, 24'h000013);
        for (i = 0; i < 15; i = i + 1)
            chk({20'h0, got[i]}, {20'h0, wexp[59-4*i -: 4]});
        results;
    end
endmodule
